// >>> inc/rcc_pkg.sv
/*
 * Constants for the slow-bus clock gate and reset cause block:
 * register offsets, field positions, reset values, timing figures
 * and the oscillator state encoding.
 * Assumes a 32-bit AHB-Lite register bus and a 25 MHz system clock.
 */
`default_nettype none
package rcc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CLOCK_GATES = 8'h1c;
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h24;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_POWER_IF_GATE = 28;
    localparam int BIT_I2C_GATE = 21;
    localparam int BIT_WINDOW_WDG_GATE = 11;
    localparam int BIT_TIMER_TWO_GATE = 0;
    localparam int FLAG_LSB = 26;
    localparam int FLAG_W = 6;
    localparam int BIT_CAUSE_CLEAR = 24;
    localparam int BIT_OSC_READY = 1;
    localparam int BIT_OSC_ENABLE = 0;
    // Flag order inside the cause field, bit 26 upward
    localparam int FL_PIN = 0;
    localparam int FL_POWER_ON = 1;
    localparam int FL_SOFTWARE = 2;
    localparam int FL_IND_WDG = 3;
    localparam int FL_WIN_WDG = 4;
    localparam int FL_LOW_POWER = 5;

    // ************************************************************
    // Reset values and masks
    // ************************************************************
    localparam logic [31:0] CLOCK_GATES_RESET = 32'h0000_0000;
    localparam logic [31:0] CLOCK_GATES_MASK = 32'h1020_0801;
    localparam logic [5:0] FLAGS_POR_VALUE = 6'h02;
    localparam logic [31:0] RESET_CAUSE_READ_MASK = 32'hfd00_0003;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int MCLK_FREQ_HZ = 25_000_000;
    localparam int OSC_FREQ_HZ = 128_000;
    localparam int OSC_OFF_EDGES = 3;

    // ************************************************************
    // Bus encodings and oscillator states
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        OSC_OFF = 2'b00,
        OSC_START = 2'b01,
        OSC_READY = 2'b10,
        OSC_STOP = 2'b11
    } osc_state_t;
endpackage
`default_nettype wire

// >>> core/slow_bus_rcc.sv
/*
 * Slow-bus clock gates, sticky reset cause flags and low-speed
 * oscillator control, reached as an AHB-Lite slave.
 * Assumes mclk at 25 MHz, rst as system reset and por as power-on
 * reset (both synchronous, active high), reset events from same-clock
 * logic, and the oscillator pins arriving asynchronously.
 */
// Register access over AHB-Lite was chosen for this implementation.
// What this block does
// - Gate register bit 28 switches the power interface clock, reset off.
// - Gate register bit 21 switches the I2C clock, reset off.
// - Gate register bit 11 switches the window watchdog clock, reset off.
// - Gate register bit 0 switches the timer two clock, reset off.
// - Low-power reset sets read-only flag bit 31, sticky until cleared.
// - Window watchdog reset sets flag bit 30, sticky until cleared.
// - Independent watchdog reset sets flag bit 29, sticky until cleared.
// - Software reset sets flag bit 28, cleared by clear bit or power-on reset.
// - Power-on reset sets flag bit 27, resets to one, sticky.
// - External reset pin sets flag bit 26, sticky until cleared.
// - Writing one to bit 24 clears all cause flags; zero does nothing.
// - Bit 0 enables the 128 kHz low-speed oscillator, resets off.
// - Read-only bit 1 shows oscillator stable.
// - After enable clears, ready falls after three oscillator cycles.
// - Of the two resets only power-on reset resets the flags, leaving just bit 27 set; system reset restores the rest.
`timescale 1ns/10ps
`default_nettype none
module slow_bus_rcc
    import rcc_pkg::*;
#(
    parameter int OFF_EDGES = OSC_OFF_EDGES
) (
    input wire logic mclk, // System clock, 25 MHz
    input wire logic rst, // System reset
    input wire logic por, // Power-on reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Response, always OKAY
    output logic power_if_clock_gate, // Power interface clock on
    output logic i2c_clock_gate, // I2C clock on
    output logic window_watchdog_clock_gate, // Window watchdog clock on
    output logic timer_two_clock_gate, // Timer two clock on
    input wire logic low_power_reset_event, // Low-power reset pulse
    input wire logic window_watchdog_reset_event, // Window watchdog reset pulse
    input wire logic independent_watchdog_reset_event, // Independent watchdog reset pulse
    input wire logic software_reset_event, // Software reset pulse
    input wire logic external_reset_pin_n, // External reset pin, async
    input wire logic osc_stable, // Oscillator stable, async
    input wire logic osc_clk, // Oscillator output, async
    output logic osc_run // Oscillator run request
);
    // Fallback stop time: one cycle beyond the documented edges
    localparam int STOP_TIMEOUT = ((OFF_EDGES + 1) * MCLK_FREQ_HZ + OSC_FREQ_HZ - 1) / OSC_FREQ_HZ;
    localparam int STOP_WAIT_MAX = 1000;
    localparam logic [11:0] STOP_TIMEOUT_C = 12'(STOP_TIMEOUT);
    localparam logic [3:0] OFF_EDGES_C = 4'(OFF_EDGES);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (OFF_EDGES < 1 || OFF_EDGES > 15) begin : g_bad_edges
        $error("OFF_EDGES must be 1 to 15");
    end
    if (STOP_TIMEOUT > STOP_WAIT_MAX - 8) begin : g_bad_timeout
        $error("stop timeout too long for the counter");
    end

    // Packs the cause and oscillator register from its fields
    function automatic logic [31:0] pack_cause(input logic [5:0] flags, input logic clr,
                                               input logic rdy, input logic en);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FLAG_LSB +: FLAG_W] = flags;
        w[BIT_CAUSE_CLEAR] = clr;
        w[BIT_OSC_READY] = rdy;
        w[BIT_OSC_ENABLE] = en;
        return w;
    endfunction

    logic sys_rst;
    logic pin_s1_q, pin_s2_q, st_s1_q, st_s2_q, ck_s1_q, ck_s2_q, ck_s3_q;
    logic wr_q, rd_q, rd_ok_q;
    logic [ADDR_W-1:0] addr_q;
    logic [31:0] hrdata_q, gates_q, read_value;
    logic [5:0] flags_q, flags_d, set_vec;
    logic clr_q, lson_q;
    osc_state_t state_q, state_d;
    logic [3:0] edges_q;
    logic [11:0] timeout_q;
    logic addr_take, sel_gates, sel_cause, wr_gates, wr_cause, clear_pulse, osc_edge, ready, stop_done;

    // Any reset brings control state home; flags listen to por alone
    assign sys_rst = rst | por;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Pins come from outside the clock domain; edge detect uses stage two
    always_ff @(posedge mclk) begin
        pin_s1_q <= ~external_reset_pin_n;
        pin_s2_q <= pin_s1_q;
        st_s1_q <= osc_stable;
        st_s2_q <= st_s1_q;
        ck_s1_q <= osc_clk;
        ck_s2_q <= ck_s1_q;
        ck_s3_q <= ck_s2_q;
    end
    assign osc_edge = ck_s2_q & ~ck_s3_q;

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    // Writes finish with no wait; reads take one wait state so that
    // the read data flop sees any write that just completed
    assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
    assign sel_gates = (addr_q == OFS_CLOCK_GATES);
    assign sel_cause = (addr_q == OFS_RESET_CAUSE);
    assign wr_gates = wr_q & sel_gates;
    assign wr_cause = wr_q & sel_cause;
    assign clear_pulse = wr_cause & hwdata[BIT_CAUSE_CLEAR];
    assign hreadyout = ~(rd_q & ~rd_ok_q);
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_q;
    // Unmapped addresses read zero and drop writes
    assign read_value = sel_gates ? gates_q :
                        sel_cause ? pack_cause(flags_q, clr_q, ready, lson_q) : 32'h0000_0000;

    // Address phase capture
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rd_ok_q <= 1'b0;
            addr_q <= '0;
        end else begin
            if (hready) begin
                wr_q <= addr_take & hwrite;
                rd_q <= addr_take & ~hwrite;
                addr_q <= haddr[ADDR_W-1:0];
            end
            rd_ok_q <= rd_q & ~rd_ok_q;
        end
    end

    // Read data loaded during the wait state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_q & ~rd_ok_q) begin
            hrdata_q <= read_value;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Only the four gate bits store; the rest stay zero
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gates_q <= CLOCK_GATES_RESET;
        end else if (wr_gates) begin
            gates_q <= hwdata & CLOCK_GATES_MASK;
        end
    end
    assign power_if_clock_gate = gates_q[BIT_POWER_IF_GATE];
    assign i2c_clock_gate = gates_q[BIT_I2C_GATE];
    assign window_watchdog_clock_gate = gates_q[BIT_WINDOW_WDG_GATE];
    assign timer_two_clock_gate = gates_q[BIT_TIMER_TWO_GATE];

    // Writable cause register bits; flags and ready ignore writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clr_q <= 1'b0;
            lson_q <= 1'b0;
        end else if (wr_cause) begin
            clr_q <= hwdata[BIT_CAUSE_CLEAR];
            lson_q <= hwdata[BIT_OSC_ENABLE];
        end
    end

    // ************************************************************
    // Reset cause flags
    // ************************************************************
    // A cause arriving with the clear write survives: set beats clear
    always_comb begin
        set_vec = 6'h00;
        set_vec[FL_LOW_POWER] = low_power_reset_event;
        set_vec[FL_WIN_WDG] = window_watchdog_reset_event;
        set_vec[FL_IND_WDG] = independent_watchdog_reset_event;
        set_vec[FL_SOFTWARE] = software_reset_event;
        set_vec[FL_PIN] = pin_s2_q;
        flags_d = (flags_q & ~{FLAG_W{clear_pulse}}) | set_vec;
    end

    // System reset leaves the flags alone so software can read the cause
    always_ff @(posedge mclk) begin
        if (por) begin
            flags_q <= FLAGS_POR_VALUE;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ************************************************************
    // Low-speed oscillator
    // ************************************************************
    // Oscillator kept running while stopping so its edges can be counted
    assign ready = (state_q == OSC_READY) | (state_q == OSC_STOP);
    assign osc_run = lson_q | (state_q == OSC_STOP);
    // Timeout guards against an oscillator that dies before three edges
    assign stop_done = ((edges_q == OFF_EDGES_C - 4'h1) & osc_edge) | (timeout_q == STOP_TIMEOUT_C);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            OSC_OFF: begin
                if (lson_q) state_d = OSC_START;
            end
            OSC_START: begin
                if (!lson_q) state_d = OSC_OFF;
                else if (st_s2_q) state_d = OSC_READY;
            end
            OSC_READY: begin
                if (!lson_q) state_d = OSC_STOP;
                else if (!st_s2_q) state_d = OSC_START;
            end
            OSC_STOP: begin
                if (lson_q) state_d = OSC_READY;
                else if (stop_done) state_d = OSC_OFF;
            end
            default: state_d = OSC_OFF;
        endcase
    end

    // State and stop counters
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= OSC_OFF;
            edges_q <= 4'h0;
            timeout_q <= 12'h000;
        end else begin
            state_q <= state_d;
            if (state_q != OSC_STOP) begin
                edges_q <= 4'h0;
                timeout_q <= 12'h000;
            end else begin
                edges_q <= edges_q + {3'h0, osc_edge};
                timeout_q <= timeout_q + 12'h001;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_gates;
        @(posedge mclk) disable iff (sys_rst)
        wr_gates |=> (power_if_clock_gate == $past(hwdata[BIT_POWER_IF_GATE]))
            && (i2c_clock_gate == $past(hwdata[BIT_I2C_GATE]))
            && (window_watchdog_clock_gate == $past(hwdata[BIT_WINDOW_WDG_GATE]))
            && (timer_two_clock_gate == $past(hwdata[BIT_TIMER_TWO_GATE]));
    endproperty
    a_gates: assert property (p_gates) else $error("clock gate outputs do not follow write");

    property p_flag_set;
        @(posedge mclk) disable iff (por)
        (set_vec != 6'h00) |=> ((flags_q & $past(set_vec)) == $past(set_vec));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("reset cause flag not set");

    property p_flag_sticky;
        @(posedge mclk) disable iff (por)
        !clear_pulse |=> ((flags_q & $past(flags_q)) == $past(flags_q));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("reset cause flag lost");

    property p_por_flag;
        @(posedge mclk)
        por ##1 !por |-> flags_q[FL_POWER_ON];
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");

    property p_clear;
        @(posedge mclk) disable iff (por)
        (clear_pulse && set_vec == 6'h00) |=> (flags_q == 6'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("clear write left flags");
    // Start from idle only; a repeated enable while running keeps its state
    property p_enable;
        @(posedge mclk) disable iff (sys_rst)
        (wr_cause && hwdata[BIT_OSC_ENABLE] && state_q == OSC_OFF) |=> osc_run ##1 (state_q == OSC_START);
    endproperty
    a_enable: assert property (p_enable) else $error("oscillator not started");
    property p_ready;
        @(posedge mclk) disable iff (sys_rst)
        $rose(ready) |-> $past(st_s2_q) && $past(lson_q);
    endproperty
    a_ready: assert property (p_ready) else $error("ready without stable oscillator");

    property p_stop_hold;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == OSC_READY && !lson_q) |=> ready [*2];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("ready fell too early");
    // A re-enable during the stop legally keeps ready up
    property p_stop_bound;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == OSC_READY && !lson_q) |=> ##[1:STOP_WAIT_MAX] (!ready || lson_q);
    endproperty
    a_stop_bound: assert property (p_stop_bound) else $error("ready never fell");
    property p_sys_reset;
        @(posedge mclk)
        rst |=> (gates_q == CLOCK_GATES_RESET) && !lson_q && !clr_q && (state_q == OSC_OFF);
    endproperty
    a_sys_reset: assert property (p_sys_reset) else $error("system reset missed a bit");

    property p_reserved;
        @(posedge mclk) disable iff (sys_rst)
        (rd_q && rd_ok_q) |-> ((hrdata & ~(RESET_CAUSE_READ_MASK | CLOCK_GATES_MASK)) == 32'h0000_0000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read non-zero");

    property p_read_wait;
        @(posedge mclk) disable iff (sys_rst)
        (rd_q && !rd_ok_q) |-> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

    c_gate_write: cover property (@(posedge mclk) disable iff (sys_rst) wr_gates);
    c_clear: cover property (@(posedge mclk) disable iff (por) clear_pulse && flags_q != 6'h00);
    c_ready: cover property (@(posedge mclk) disable iff (sys_rst) $rose(ready));
    c_stop: cover property (@(posedge mclk) disable iff (sys_rst) $fell(ready) && edges_q != 4'h0);
endmodule
`default_nettype wire

// >>> verification/test_slow_bus_rcc.sv
/*
 * Self-checking bench for the slow-bus clock gate and reset cause block.
 * Assumes a single AHB-Lite slave (hready tied to hreadyout), reset
 * events from same-clock logic and an oscillator clock made here.
 */
`timescale 1ns/10ps
`default_nettype none
module test_slow_bus_rcc;
    import rcc_pkg::*;

    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0] ev = 4'h0;
    logic pin_n = 1'b1;
    logic osc_stable = 1'b1;
    logic osc_clk = 1'b0;
    logic [1:0] div = 2'h0;
    logic hreadyout, hresp, osc_run;
    logic [31:0] hrdata, rd;
    logic g_pwr, g_i2c, g_wdg, g_tim;
    int fails = 0;
    int checks_done = 0;

    // 25 MHz system clock
    always #20 mclk = ~mclk;

    // Oscillator output, toggles every 3 cycles and only while requested
    always @(posedge mclk) begin
        if (osc_run === 1'b1) begin
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (div == 2'h2) begin
                osc_clk <= ~osc_clk;
            end
        end
    end

    slow_bus_rcc dut (
        .mclk(mclk), .rst(rst), .por(por), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .power_if_clock_gate(g_pwr), .i2c_clock_gate(g_i2c),
        .window_watchdog_clock_gate(g_wdg), .timer_two_clock_gate(g_tim),
        .low_power_reset_event(ev[3]), .window_watchdog_reset_event(ev[2]),
        .independent_watchdog_reset_event(ev[1]), .software_reset_event(ev[0]),
        .external_reset_pin_n(pin_n), .osc_stable(osc_stable), .osc_clk(osc_clk),
        .osc_run(osc_run)
    );

    // ************************************************************
    // Verdict and comparison
    // ************************************************************
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // ************************************************************
    // Bus master
    // ************************************************************
    // Looks at hreadyout half a cycle early so the sampled value is settled
    task automatic wait_ready(output logic [31:0] data);
        int n;
        n = 0;
        @(negedge mclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(negedge mclk);
        end
        if (hreadyout !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t bus never ready", $time);
            report_and_stop();
        end
        data = hrdata;
        @(posedge mclk);
    endtask

    // Select stays high between transfers; IDLE alone ends each one
    task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        wait_ready(dummy);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus_xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp, what);
    endtask

    // Outputs settle after the write edge; look mid-cycle
    task automatic pins_check(input logic [31:0] exp, input string what);
        @(negedge mclk);
        check({27'h0, osc_run, g_pwr, g_i2c, g_wdg, g_tim}, exp, what);
        @(posedge mclk);
    endtask

    task automatic hold_reset(input logic with_por);
        rst <= 1'b1;
        por <= with_por;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        por <= 1'b0;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    logic [31:0] exp;
    int gate_bit [4] = '{28, 21, 11, 0};
    int i, n;
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        por <= 1'b0;
        rd_check(OFS_CLOCK_GATES, 32'h0000_0000, "gates after por");
        rd_check(OFS_RESET_CAUSE, 32'h0800_0000, "cause after por");
        pins_check(32'h0000_0000, "pins after por");
        // One gate at a time, outputs and read-back
        for (i = 0; i < 4; i++) begin
            bus_xfer(1'b1, OFS_CLOCK_GATES, 32'h0000_0001 << gate_bit[i]);
            pins_check(32'h0000_0008 >> i, "gate output");
            rd_check(OFS_CLOCK_GATES, 32'h0000_0001 << gate_bit[i], "gate readback");
        end
        bus_xfer(1'b1, OFS_CLOCK_GATES, 32'hffff_ffff);
        rd_check(OFS_CLOCK_GATES, 32'h1020_0801, "gate reserved bits");
        bus_xfer(1'b1, 8'h40, 32'hffff_ffff);
        rd_check(8'h40, 32'h0000_0000, "unmapped offset");
        // Clear first, then set each cause in turn and watch them pile up
        bus_xfer(1'b1, OFS_RESET_CAUSE, 32'h0100_0000);
        rd_check(OFS_RESET_CAUSE, 32'h0100_0000, "clear power-on flag");
        bus_xfer(1'b1, OFS_RESET_CAUSE, 32'h0000_0000);
        exp = 32'h0000_0000;
        for (i = 0; i < 4; i++) begin
            ev <= 4'h1 << i;
            @(posedge mclk);
            ev <= 4'h0;
            repeat (2) @(posedge mclk);
            exp = exp | (32'h1000_0000 << i);
            rd_check(OFS_RESET_CAUSE, exp, "event cause flag");
        end
        pin_n <= 1'b0;
        repeat (3) @(posedge mclk);
        pin_n <= 1'b1;
        repeat (4) @(posedge mclk);
        exp = exp | 32'h0400_0000;
        rd_check(OFS_RESET_CAUSE, exp, "pin cause flag");
        bus_xfer(1'b1, OFS_RESET_CAUSE, 32'h0000_0000);
        rd_check(OFS_RESET_CAUSE, exp, "zero write keeps flags");
        bus_xfer(1'b1, OFS_RESET_CAUSE, 32'hffff_fffe);
        rd_check(OFS_RESET_CAUSE, 32'h0100_0000, "clear and read-only bits");
        // System reset keeps flags but restores everything else
        ev <= 4'h1;
        @(posedge mclk);
        ev <= 4'h0;
        bus_xfer(1'b1, OFS_CLOCK_GATES, 32'hffff_ffff);
        hold_reset(1'b0);
        rd_check(OFS_CLOCK_GATES, 32'h0000_0000, "gates after system reset");
        rd_check(OFS_RESET_CAUSE, 32'h1000_0000, "flags survive system reset");
        hold_reset(1'b1);
        rd_check(OFS_RESET_CAUSE, 32'h0800_0000, "flags after power-on reset");
        // Oscillator held unready while unstable, then ready, then a delayed fall
        osc_stable <= 1'b0;
        bus_xfer(1'b1, OFS_RESET_CAUSE, 32'h0000_0001);
        pins_check(32'h0000_0010, "oscillator requested");
        repeat (4) @(posedge mclk);
        rd_check(OFS_RESET_CAUSE, 32'h0800_0001, "not ready while unstable");
        osc_stable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            bus_xfer(1'b0, OFS_RESET_CAUSE, 32'h0000_0000);
            if (rd[1] === 1'b1) break;
        end
        check(rd, 32'h0800_0003, "oscillator ready");
        bus_xfer(1'b1, OFS_RESET_CAUSE, 32'h0000_0000);
        rd_check(OFS_RESET_CAUSE, 32'h0800_0002, "ready held after disable");
        for (n = 0; n < 40; n++) begin
            bus_xfer(1'b0, OFS_RESET_CAUSE, 32'h0000_0000);
            if (rd[1] !== 1'b1) break;
        end
        check(rd, 32'h0800_0000, "ready dropped");
        pins_check(32'h0000_0000, "oscillator stopped");
        check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "bus response");
        report_and_stop();
    end
endmodule
`default_nettype wire
